// *** serial_status_pkg.sv ***
// Package: register map, field positions and carrier types of the serial port pin status block
package serial_status_pkg;

	// ****************************************
	// Register map (byte addresses, Wishbone)
	// ****************************************
	localparam logic [15:0] STATUS_REG_IDX = 16'hFFF6;
	localparam logic [17:0] STATUS_ADDR = {STATUS_REG_IDX, 2'b00};
	localparam logic [17:0] CONTROL_ADDR = 18'h3FFE0;
	localparam logic [17:0] RXDATA_ADDR = 18'h3FFE4;
	localparam logic [17:0] IRQ_STATUS_ADDR = 18'h3FFE8;
	localparam logic [17:0] IRQ_MASK_ADDR = 18'h3FFEC;
	localparam logic [17:0] RXLOAD_ADDR = 18'h3FFF0;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int PIN_LEVEL_LSB = 0;
	localparam int CHANGE_FLAG_LSB = 4;
	localparam int RX_READY_BIT = 8;
	localparam int PORT_ENABLE_BIT = 4;
	localparam int IRQ_RX_BIT = 0;
	localparam int IRQ_PIN_LSB = 1;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [3:0] DIRECTION_RST = 4'h0;
	localparam logic PORT_ENABLE_RST = 1'b0;
	localparam logic [4:0] IRQ_MASK_RST = 5'h00;
	localparam logic [7:0] RX_DATA_RST = 8'h00;
	localparam logic [3:0] PIN_OUT_RST = 4'h0;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic [17:0] adr;
		logic [31:0] datW;
		logic [3:0] sel;
		logic we;
		logic stb;
		logic cyc;
	} wb_req_t;

	typedef struct packed {
		logic [3:0] pinIn;
		logic [7:0] rxChar;
		logic rxStrobe;
	} link_in_t;

endpackage : serial_status_pkg

// *** serial_port_pin_status_detect.sv ***
// Module: serial port status low half with pin change detect and Wishbone slave
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
module serial_port_pin_status_detect
	import serial_status_pkg::*;
#(
	parameter int PIN_COUNT = 4
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire wb_req_t wbReq,
	output logic [31:0] wbDatR,
	output logic wbAck,
	output logic wbErr,
	input wire link_in_t linkIn,
	output logic [3:0] pinOut,
	output logic [3:0] pinOe,
	output logic serialSharedIrq
);

	if (PIN_COUNT != 4) begin : g_bad_pins
		$error("PIN_COUNT must be 4");
	end

	// ****************************************
	// State
	// ****************************************
	logic [3:0] pinSyncA_r, pinSync_r, pinPrev_r;
	logic [3:0] pinSyncA_nxt, pinSync_nxt, pinPrev_nxt;
	logic [3:0] changeFlag_r, changeFlag_nxt;
	logic [3:0] direction_r, direction_nxt;
	logic [3:0] pinOut_r, pinOut_nxt;
	logic portEnable_r, portEnable_nxt;
	logic rxReady_r, rxReady_nxt;
	logic [7:0] rxData_r, rxData_nxt;
	logic [4:0] irqStatus_r, irqStatus_nxt;
	logic [4:0] irqMask_r, irqMask_nxt;
	logic [31:0] datR_r, datR_nxt;
	logic ack_r, ack_nxt;
	logic err_r, err_nxt;
	logic irq_r, irq_nxt;
	logic [3:0] pinChange;
	logic rxEvent;
	logic access, wrLow, wrHigh;

	function automatic logic hit(input logic [17:0] a, input logic [17:0] base);
		hit = (a == base);
	endfunction : hit

	function automatic logic mapped(input logic [17:0] a);
		mapped = hit(a, STATUS_ADDR) || hit(a, CONTROL_ADDR) || hit(a, RXDATA_ADDR)
			|| hit(a, IRQ_STATUS_ADDR) || hit(a, IRQ_MASK_ADDR) || hit(a, RXLOAD_ADDR);
	endfunction : mapped

	// ****************************************
	// Pin sampling and change detect
	// ****************************************
	// Either edge counts; a pulse shorter than one clock may go unseen
	always_comb begin
		pinSyncA_nxt = linkIn.pinIn;
		pinSync_nxt = pinSyncA_r;
		pinPrev_nxt = pinSync_r;
	end

	genvar gi;
	for (gi = 0; gi < 4; gi++) begin : g_pin
		assign pinChange[gi] = (pinSync_r[gi] != pinPrev_r[gi])
			&& !direction_r[gi] && portEnable_r;
	end

	// ****************************************
	// Bus decode
	// ****************************************
	// Ack is registered, so every access takes exactly one wait cycle
	assign access = wbReq.cyc && wbReq.stb && !ack_r && !err_r;
	assign wrLow = access && wbReq.we && wbReq.sel[0];
	assign wrHigh = access && wbReq.we && wbReq.sel[1];
	// Receiver model: an external strobe loads a character; software may also load one
	assign rxEvent = linkIn.rxStrobe || (wrLow && hit(wbReq.adr, RXLOAD_ADDR));

	// Unmapped addresses answer with err and change nothing
	always_comb begin
		changeFlag_nxt = changeFlag_r;
		direction_nxt = direction_r;
		pinOut_nxt = pinOut_r;
		portEnable_nxt = portEnable_r;
		rxReady_nxt = rxReady_r;
		rxData_nxt = rxData_r;
		irqStatus_nxt = irqStatus_r;
		irqMask_nxt = irqMask_r;
		datR_nxt = 32'h0000_0000;
		ack_nxt = 1'b0;
		err_nxt = 1'b0;
		if (access) begin
			ack_nxt = 1'b1;
			case (1'b1)
				hit(wbReq.adr, STATUS_ADDR): begin
					datR_nxt[RX_READY_BIT] = rxReady_r;
					datR_nxt[CHANGE_FLAG_LSB +: 4] = changeFlag_r;
					for (int i = 0; i < 4; i++) begin
						datR_nxt[PIN_LEVEL_LSB + i] = direction_r[i] ? pinOut_r[i]
							: pinSync_r[i];
					end
					if (wrLow) begin
						changeFlag_nxt = changeFlag_r & ~wbReq.datW[CHANGE_FLAG_LSB +: 4];
						pinOut_nxt = wbReq.datW[PIN_LEVEL_LSB +: 4];
					end
				end
				hit(wbReq.adr, CONTROL_ADDR): begin
					datR_nxt[3:0] = direction_r;
					datR_nxt[PORT_ENABLE_BIT] = portEnable_r;
					if (wrLow) begin
						direction_nxt = wbReq.datW[3:0];
						portEnable_nxt = wbReq.datW[PORT_ENABLE_BIT];
					end
				end
				hit(wbReq.adr, RXDATA_ADDR): begin
					datR_nxt[7:0] = rxData_r;
					if (!wbReq.we) begin
						rxReady_nxt = 1'b0;
					end
				end
				hit(wbReq.adr, IRQ_STATUS_ADDR): begin
					datR_nxt[4:0] = irqStatus_r;
					if (wrLow) begin
						irqStatus_nxt = irqStatus_r & ~wbReq.datW[4:0];
					end
				end
				hit(wbReq.adr, IRQ_MASK_ADDR): begin
					datR_nxt[4:0] = irqMask_r;
					if (wrLow) begin
						irqMask_nxt = wbReq.datW[4:0];
					end
				end
				hit(wbReq.adr, RXLOAD_ADDR): begin
				end
				default: begin
					ack_nxt = 1'b0;
					err_nxt = 1'b1;
				end
			endcase
		end
		// Hardware set wins over software clear in the same cycle
		changeFlag_nxt = changeFlag_nxt | pinChange;
		if (rxEvent) begin
			rxReady_nxt = 1'b1;
			rxData_nxt = linkIn.rxStrobe ? linkIn.rxChar : wbReq.datW[7:0];
		end
		irqStatus_nxt[IRQ_RX_BIT] = irqStatus_nxt[IRQ_RX_BIT] | rxEvent;
		irqStatus_nxt[IRQ_PIN_LSB +: 4] = irqStatus_nxt[IRQ_PIN_LSB +: 4] | pinChange;
		irq_nxt = |(irqStatus_nxt & irqMask_nxt);
	end

	// Upper byte lane holds nothing writable here
	logic unusedHigh;
	assign unusedHigh = wrHigh;

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pinSyncA_r <= 4'h0;
			pinSync_r <= 4'h0;
			pinPrev_r <= 4'h0;
			changeFlag_r <= 4'h0;
			direction_r <= DIRECTION_RST;
			pinOut_r <= PIN_OUT_RST;
			portEnable_r <= PORT_ENABLE_RST;
			rxReady_r <= 1'b0;
			rxData_r <= RX_DATA_RST;
			irqStatus_r <= 5'h00;
			irqMask_r <= IRQ_MASK_RST;
			datR_r <= 32'h0000_0000;
			ack_r <= 1'b0;
			err_r <= 1'b0;
			irq_r <= 1'b0;
			pinOut <= 4'h0;
			pinOe <= 4'h0;
		end else begin
			pinSyncA_r <= pinSyncA_nxt;
			pinSync_r <= pinSync_nxt;
			pinPrev_r <= pinPrev_nxt;
			changeFlag_r <= changeFlag_nxt;
			direction_r <= direction_nxt;
			pinOut_r <= pinOut_nxt;
			portEnable_r <= portEnable_nxt;
			rxReady_r <= rxReady_nxt;
			rxData_r <= rxData_nxt;
			irqStatus_r <= irqStatus_nxt;
			irqMask_r <= irqMask_nxt;
			datR_r <= datR_nxt;
			ack_r <= ack_nxt;
			err_r <= err_nxt;
			irq_r <= irq_nxt;
			pinOut <= pinOut_nxt;
			pinOe <= direction_nxt;
		end
	end

	assign wbDatR = datR_r;
	assign wbAck = ack_r;
	assign wbErr = err_r;
	assign serialSharedIrq = irq_r;

	// ****************************************
	// Assertions: receiver and interrupt level
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Bus request fields trigger checks; a_flag_write_clear, a_out_drive and a_out_level also compare against past datW

	a_rx_ready_set: assert property (rxEvent |=> rxReady_r)
		else $error("data ready not set after receive");
	a_rx_data_load: assert property (linkIn.rxStrobe
		|=> rxData_r == $past(linkIn.rxChar))
		else $error("received character not held");
	a_rx_ready_hold: assert property (rxReady_r
		&& !(access && !wbReq.we && hit(wbReq.adr, RXDATA_ADDR)) |=> rxReady_r)
		else $error("data ready lost without a read");
	a_rx_read_clear: assert property (access && !wbReq.we
		&& hit(wbReq.adr, RXDATA_ADDR) && !rxEvent |=> !rxReady_r)
		else $error("data ready not cleared by read");
	a_rx_irq_raise: assert property (rxEvent && irqMask_r[IRQ_RX_BIT] && !access
		|=> serialSharedIrq)
		else $error("receive did not raise interrupt");
	a_irq_level: assert property (serialSharedIrq == |(irqStatus_r & irqMask_r))
		else $error("interrupt level differs from masked status");

	// ****************************************
	// Assertions: pins
	// ****************************************
	a_change_flag_set: assert property (pinChange != 4'h0
		|=> (changeFlag_r & $past(pinChange)) == $past(pinChange))
		else $error("change flag not set");
	a_flag_sticky: assert property (!(wrLow && hit(wbReq.adr, STATUS_ADDR))
		|=> (changeFlag_r & $past(changeFlag_r)) == $past(changeFlag_r))
		else $error("change flag lost without a clear");
	a_change_gated_off: assert property (!portEnable_r |-> pinChange == 4'h0)
		else $error("change seen while port disabled");
	a_out_dir_gate: assert property ((pinChange & direction_r) == 4'h0)
		else $error("change seen on an output pin");
	a_flag_write_clear: assert property (wrLow && hit(wbReq.adr, STATUS_ADDR)
		&& pinChange == 4'h0
		|=> changeFlag_r == ($past(changeFlag_r) & ~$past(wbReq.datW[7:4])))
		else $error("change flag write-one clear wrong");
	a_pin_irq_raise: assert property (pinChange != 4'h0
		&& (irqMask_r[4:1] & pinChange) != 4'h0 && !access |=> serialSharedIrq)
		else $error("pin change did not raise interrupt");
	a_irq_pin_status: assert property (pinChange != 4'h0
		|=> (irqStatus_r[4:1] & $past(pinChange)) == $past(pinChange))
		else $error("pin change not recorded in interrupt status");
	a_level_read: assert property (access && !wbReq.we
		&& hit(wbReq.adr, STATUS_ADDR)
		|=> wbDatR[3:0] == (($past(direction_r) & $past(pinOut_r))
		| (~$past(direction_r) & $past(pinSync_r))))
		else $error("pin level readback wrong");
	a_out_drive: assert property (wrLow && hit(wbReq.adr, CONTROL_ADDR)
		|=> pinOe == $past(wbReq.datW[3:0]))
		else $error("pin direction not driven");
	a_out_level: assert property (wrLow && hit(wbReq.adr, STATUS_ADDR)
		|=> pinOut == $past(wbReq.datW[PIN_LEVEL_LSB +: 4]))
		else $error("pin output level not driven");
	// The previous sample is the one taken one edge earlier
	a_sync_change: assert property (portEnable_r && !direction_r[0]
		&& pinSync_r[0] != $past(pinSync_r[0]) |-> pinChange[0])
		else $error("synchronised edge missed");

	// ****************************************
	// Assertions: register bus
	// ****************************************
	a_ack_single: assert property (wbAck |=> !wbAck)
		else $error("ack held more than one cycle");
	a_answer_once: assert property (access |=> wbAck != wbErr)
		else $error("access not answered by exactly one of ack and err");
	a_err_unmapped: assert property (access && !mapped(wbReq.adr)
		|=> wbErr && wbDatR == 32'h0000_0000)
		else $error("unmapped access not refused");
	a_data_idle: assert property (!wbAck |-> wbDatR == 32'h0000_0000)
		else $error("read data not zero outside ack");

	// ****************************************
	// Cover points
	// ****************************************
	c_rx_then_read: cover property (rxEvent ##[1:20] (access && hit(wbReq.adr, RXDATA_ADDR)));
	c_pin_change_irq: cover property (pinChange != 4'h0 ##1 serialSharedIrq);
	c_flag_cleared: cover property ($fell(changeFlag_r[0]));
	c_output_drive: cover property ($rose(pinOe[3]));
	c_soft_load: cover property (wrLow && hit(wbReq.adr, RXLOAD_ADDR));

endmodule : serial_port_pin_status_detect

// *** pin_partner.sv ***
// Partner model: outside drivers on the four general-purpose pins
`timescale 1ns/1ps
module pin_partner (
	input wire logic [3:0] pinOut,
	input wire logic [3:0] pinOe,
	input wire logic [3:0] extLevel,
	output logic [3:0] pinWire
);
	// Outside driver backs off while the device drives, so no contention
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pinWire[i] = pinOe[i] ? pinOut[i] : extLevel[i];
		end
	end
endmodule : pin_partner

// *** tb.sv ***
// Testbench: register, pin change, receiver and interrupt checks of the serial status block
`timescale 1ns/1ps
module tb;
	import serial_status_pkg::*;
	logic core_clk, reset_n, wbAck, wbErr, serialSharedIrq, rxStrobe, e;
	logic [7:0] rxChar;
	logic [31:0] wbDatR, rd;
	logic [3:0] pinOut, pinOe, extLevel, pinWire;
	wb_req_t wbReq;
	link_in_t linkIn;
	int fail_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	assign linkIn = {pinWire, rxChar, rxStrobe};
	serial_port_pin_status_detect serial_port_pin_status_detect_i (.core_clk(core_clk),
		.reset_n(reset_n), .wbReq(wbReq), .wbDatR(wbDatR), .wbAck(wbAck), .wbErr(wbErr),
		.linkIn(linkIn), .pinOut(pinOut), .pinOe(pinOe), .serialSharedIrq(serialSharedIrq));
	pin_partner pin_partner_i (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel),
		.pinWire(pinWire));
	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic xfer(input logic [17:0] a, input logic w, input logic [31:0] d);
		@(posedge core_clk);
		wbReq <= '{adr: a, datW: d, sel: 4'hF, we: w, stb: 1'b1, cyc: 1'b1};
		do @(posedge core_clk); while (!(wbAck || wbErr));
		rd = wbDatR;
		e = wbErr;
		wbReq <= '0;
		@(posedge core_clk);
	endtask : xfer
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	task automatic rdchk(input logic [17:0] a, input logic [31:0] x, input string n);
		xfer(a, 1'b0, 32'h0);
		chk(n, x, rd);
	endtask : rdchk
	task automatic stop_test;
		$display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : stop_test
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// Cut short a hang
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			stop_test();
		end
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		reset_n = 1'b0;
		wbReq = '0;
		rxChar = 8'h00;
		rxStrobe = 1'b0;
		extLevel = 4'h0;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		rdchk(CONTROL_ADDR, 32'h0, "control");
		rdchk(STATUS_ADDR, 32'h0, "status");
		chk("pinOe", 32'h0, {28'h0, pinOe});
		$display("test reset done");
		xfer(CONTROL_ADDR, 1'b1, 32'h10);
		xfer(IRQ_MASK_ADDR, 1'b1, 32'h1F);
		for (int i = 0; i < 4; i++) begin
			extLevel[i] <= 1'b1;
			repeat (6) @(posedge core_clk);
			chk("irq", 32'h1, {31'h0, serialSharedIrq});
			rdchk(STATUS_ADDR, (32'h10 << i) | ((32'h2 << i) - 1), "flag");
			xfer(STATUS_ADDR, 1'b1, 32'h0);
			rdchk(STATUS_ADDR, (32'h10 << i) | ((32'h2 << i) - 1), "keep");
			xfer(STATUS_ADDR, 1'b1, 32'h10 << i);
			xfer(IRQ_STATUS_ADDR, 1'b1, 32'h1F);
			rdchk(STATUS_ADDR, (32'h2 << i) - 1, "clear");
			chk("irqClr", 32'h0, {31'h0, serialSharedIrq});
		end
		$display("test pin change done");
		// Port disabled, pin 0 output: no change may be flagged
		xfer(CONTROL_ADDR, 1'b1, 32'h01);
		extLevel <= 4'h0;
		repeat (6) @(posedge core_clk);
		rdchk(STATUS_ADDR, 32'h0, "disabled");
		xfer(CONTROL_ADDR, 1'b1, 32'h11);
		xfer(STATUS_ADDR, 1'b1, 32'h1);
		chk("drive", 32'h11, {24'h0, pinOe, pinOut});
		extLevel <= 4'hE;
		repeat (6) @(posedge core_clk);
		rdchk(STATUS_ADDR, 32'hEF, "direction");
		xfer(IRQ_STATUS_ADDR, 1'b1, 32'h1F);
		xfer(STATUS_ADDR, 1'b1, 32'hF0);
		xfer(CONTROL_ADDR, 1'b1, 32'h0);
		$display("test gating done");
		rxChar <= 8'hA5;
		rxStrobe <= 1'b1;
		@(posedge core_clk);
		rxStrobe <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("rxIrq", 32'h1, {31'h0, serialSharedIrq});
		rdchk(STATUS_ADDR, 32'h10E, "ready");
		xfer(IRQ_MASK_ADDR, 1'b1, 32'h0);
		chk("masked", 32'h0, {31'h0, serialSharedIrq});
		xfer(IRQ_MASK_ADDR, 1'b1, 32'h1);
		chk("unmasked", 32'h1, {31'h0, serialSharedIrq});
		rdchk(RXDATA_ADDR, 32'hA5, "rxData");
		rdchk(STATUS_ADDR, 32'h00E, "readClr");
		xfer(IRQ_STATUS_ADDR, 1'b1, 32'h1);
		chk("rxIrqClr", 32'h0, {31'h0, serialSharedIrq});
		xfer(RXLOAD_ADDR, 1'b1, 32'h5A);
		rdchk(STATUS_ADDR, 32'h10E, "softReady");
		chk("softIrq", 32'h1, {31'h0, serialSharedIrq});
		rdchk(RXDATA_ADDR, 32'h5A, "softData");
		xfer(18'h00000, 1'b0, 32'h0);
		chk("unmapped", 32'h1, {31'h0, e});
		$display("test receiver done");
		stop_test();
	end
endmodule : tb
